// ### design/robot_dedicated_io_control.sv
// Dedicated discrete I/O command interpreter with an APB register slave.
`timescale 1ns/100ps
`default_nettype none
`include "robot_io_map.svh"

module robot_dedicated_io_control import robot_io_pkg::*; #(
	parameter int NUM_MECH = 3,
	parameter int NUM_SLOTS = 32,
	parameter int DATA_W = 16,
	parameter int GP_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire cmd_in_t cmd_in,
	input wire logic [NUM_SLOTS-1:0] slot_start,
	input wire logic [NUM_SLOTS-1:0] slot_stop,
	input wire logic [DATA_W-1:0] numeric_value_in,
	input wire logic estop_event,
	output stat_out_t stat_out,
	output logic [NUM_SLOTS-1:0] slot_operating,
	output logic [NUM_SLOTS-1:0] slot_waiting,
	output logic [DATA_W-1:0] numeric_value_out,
	output logic [NUM_MECH-1:0] servo_power,
	output logic [GP_W-1:0] general_out,
	output logic irq
);

	// ----------------------------------------------------------------
	// Input qualification
	// ----------------------------------------------------------------
	cmd_in_t cmd_prev_q;
	cmd_in_t rise;
	logic [NUM_SLOTS-1:0] start_prev_q;
	logic [NUM_SLOTS-1:0] start_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_prev_q <= '0;
			start_prev_q <= '0;
		end else begin
			cmd_prev_q <= cmd_in;
			start_prev_q <= slot_start;
		end
	end

	assign rise = cmd_in_t'(cmd_in & ~cmd_prev_q);
	assign start_rise = slot_start & ~start_prev_q;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic wr_en;
	logic setup;
	logic hit;
	logic [31:0] rd_word;
	logic [31:0] prdata_q;
	logic rights_en_q;
	logic [`RIO_IRQ_W-1:0] irq_stat_q;
	logic [`RIO_IRQ_W-1:0] irq_mask_q;
	logic [`RIO_IRQ_W-1:0] irq_clr;
	logic [GP_W-1:0] gp_q;
	logic [DATA_W-1:0] line_q;
	logic [DATA_W-1:0] prog_q;
	logic [DATA_W-1:0] ovrd_q;
	logic [NUM_MECH-1:0] servo_pwr_q;
	logic [NUM_SLOTS-1:0] run_q;
	logic [31:0] status_word;
	logic lock_q;
	logic evasion_q;
	logic estop_q;
	logic rights_q;
	logic servo_off_q;
	readback_t rb_q;
	readback_t rb_d;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & hit;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_q;

	always_comb begin
		hit = 1'b1;
		case (paddr)
			`RIO_CTRL_OFS: rd_word = 32'(rights_en_q);
			`RIO_STATUS_OFS: rd_word = status_word;
			`RIO_EVENT_OFS: rd_word = 32'h00000000;
			`RIO_SLOT_OFS: rd_word = 32'(run_q);
			`RIO_GPOUT_OFS: rd_word = 32'(gp_q);
			`RIO_LINE_OFS: rd_word = 32'(line_q);
			`RIO_SEL_OFS: rd_word = 32'({ovrd_q, prog_q});
			`RIO_IRQ_STAT_OFS: rd_word = 32'(irq_stat_q);
			`RIO_IRQ_MASK_OFS: rd_word = 32'(irq_mask_q);
			default: begin
				hit = 1'b0;
				rd_word = 32'h00000000;
			end
		endcase
	end

	// Read data is captured in the setup cycle so it leaves a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_q <= rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rights_en_q <= `RIO_CTRL_RST;
			irq_mask_q <= `RIO_IRQ_MASK_RST;
			line_q <= '0;
		end else if (wr_en) begin
			if (paddr == `RIO_CTRL_OFS) begin
				rights_en_q <= pwdata[`RIO_CTRL_RIGHTS_BIT];
			end
			if (paddr == `RIO_IRQ_MASK_OFS) begin
				irq_mask_q <= pwdata[`RIO_IRQ_W-1:0];
			end
			if (paddr == `RIO_LINE_OFS) begin
				line_q <= pwdata[DATA_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Servo power, rights and machine lock
	// ----------------------------------------------------------------
	logic ev_wr;
	assign ev_wr = wr_en && (paddr == `RIO_EVENT_OFS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			servo_pwr_q <= '0;
		end else if (cmd_in.servo_off_hold || estop_event) begin
			servo_pwr_q <= '0;
		end else if (rise.servo_power_request) begin
			servo_pwr_q <= '1;
		end else if (ev_wr) begin
			servo_pwr_q <= servo_pwr_q &
				~pwdata[`RIO_EV_MECH_DROP_LSB +: NUM_MECH];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			servo_off_q <= 1'b0;
			rights_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			servo_off_q <= cmd_in.servo_off_hold;
			rights_q <= cmd_in.external_control_rights & rights_en_q;
			if (rise.machine_lock_toggle) begin
				lock_q <= ~lock_q;
			end
		end
	end

	assign servo_power = servo_pwr_q;

	// ----------------------------------------------------------------
	// Evasion return, emergency stop and general outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evasion_q <= 1'b0;
			estop_q <= 1'b0;
		end else begin
			if (rise.evasion_return_request) begin
				evasion_q <= 1'b1;
			end else if (ev_wr && pwdata[`RIO_EV_EVASION_DONE_BIT]) begin
				evasion_q <= 1'b0;
			end
			if (estop_event) begin
				estop_q <= 1'b1;
			end else if (ev_wr && pwdata[`RIO_EV_ESTOP_CLR_BIT]) begin
				estop_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp_q <= '0;
		end else if (rise.general_output_clear) begin
			gp_q <= '0;
		end else if (wr_en && paddr == `RIO_GPOUT_OFS) begin
			gp_q <= pwdata[GP_W-1:0];
		end
	end

	assign general_out = gp_q;

	// ----------------------------------------------------------------
	// Per-slot start and stop
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				run_q[i] <= 1'b0;
			end else if (start_rise[i]) begin
				run_q[i] <= 1'b1;
			end else if (estop_event) begin
				run_q[i] <= 1'b0;
			end else if (wr_en && paddr == `RIO_SLOT_OFS && pwdata[i]) begin
				run_q[i] <= 1'b0;
			end
		end
		assign slot_operating[i] = run_q[i] & ~slot_stop[i];
		assign slot_waiting[i] = run_q[i] & slot_stop[i];
	end

	// ----------------------------------------------------------------
	// Numeric selection and readback
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_q <= '0;
			ovrd_q <= '0;
		end else begin
			if (rise.program_number_latch) begin
				prog_q <= numeric_value_in;
			end
			if (rise.override_value_latch) begin
				ovrd_q <= numeric_value_in;
			end
		end
	end

	// The latest readback request owns the bus; program wins a tie.
	always_comb begin
		rb_d = rb_q;
		if (rise.program_name_readback) begin
			rb_d = RB_PROG;
		end else if (rise.line_number_readback) begin
			rb_d = RB_LINE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rb_q <= RB_IDLE;
			numeric_value_out <= '0;
		end else begin
			rb_q <= rb_d;
			case (rb_d)
				RB_PROG: numeric_value_out <= prog_q;
				RB_LINE: numeric_value_out <= line_q;
				default: numeric_value_out <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status outputs and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		stat_out.servo_off_echo = servo_off_q;
		stat_out.in_servo_on = |servo_pwr_q;
		stat_out.rights_valid = rights_q;
		stat_out.machine_locked = lock_q;
		stat_out.evasion_busy = evasion_q;
		stat_out.emergency_stop_flag = estop_q;
		stat_out.program_name_flag = (rb_q == RB_PROG);
		stat_out.line_number_flag = (rb_q == RB_LINE);
	end

	always_comb begin
		status_word = 32'h00000000;
		status_word[`RIO_ST_SERVO_ANY_BIT] = |servo_pwr_q;
		status_word[`RIO_ST_SERVO_OFF_BIT] = servo_off_q;
		status_word[`RIO_ST_RIGHTS_BIT] = rights_q;
		status_word[`RIO_ST_LOCK_BIT] = lock_q;
		status_word[`RIO_ST_EVASION_BIT] = evasion_q;
		status_word[`RIO_ST_ESTOP_BIT] = estop_q;
		status_word[`RIO_ST_MECH_LSB +: NUM_MECH] = servo_pwr_q;
	end

	logic [`RIO_IRQ_W-1:0] irq_set;
	always_comb begin
		irq_set = '0;
		irq_set[`RIO_IRQ_ESTOP_BIT] = estop_event;
		irq_set[`RIO_IRQ_EVASION_BIT] = rise.evasion_return_request;
		irq_set[`RIO_IRQ_SLOT_BIT] = |start_rise;
		irq_set[`RIO_IRQ_PROG_BIT] = rise.program_number_latch;
		irq_set[`RIO_IRQ_OVRD_BIT] = rise.override_value_latch;
		irq_set[`RIO_IRQ_SERVO_BIT] = rise.servo_power_request;
	end

	// A read clears only the bits it reported; a new event wins.
	assign irq_clr = (psel && penable && !pwrite &&
		paddr == `RIO_IRQ_STAT_OFS) ? prdata_q[`RIO_IRQ_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_servo_off;
		cmd_in.servo_off_hold |=> servo_pwr_q == '0 && servo_off_q;
	endproperty
	a_servo_off: assert property (p_servo_off)
		else $error("servo not off under servo-off hold");
	sequence s_servo_req;
		rise.servo_power_request && !cmd_in.servo_off_hold && !estop_event;
	endsequence
	property p_servo_on;
		s_servo_req |=> (&servo_pwr_q) && stat_out.in_servo_on;
	endproperty
	a_servo_on: assert property (p_servo_on)
		else $error("servo-on edge did not power all mechanisms");
	property p_any_servo;
		$rose(servo_pwr_q[0]) |-> stat_out.in_servo_on;
	endproperty
	a_any_servo: assert property (p_any_servo)
		else $error("in-servo-on missing with a powered mechanism");
	property p_rights;
		cmd_in.external_control_rights && rights_en_q |=> rights_q;
	endproperty
	a_rights: assert property (p_rights)
		else $error("rights not reported valid");
	property p_lock;
		rise.machine_lock_toggle |=> lock_q != $past(lock_q);
	endproperty
	a_lock: assert property (p_lock)
		else $error("machine lock did not change on edge");
	sequence s_evasion_start;
		rise.evasion_return_request ##1 evasion_q;
	endsequence
	property p_evasion;
		rise.evasion_return_request |-> s_evasion_start;
	endproperty
	a_evasion: assert property (p_evasion)
		else $error("evasion busy not raised after request");
	property p_gp_clear;
		rise.general_output_clear |=> general_out == '0;
	endproperty
	a_gp_clear: assert property (p_gp_clear)
		else $error("general outputs not cleared");
	property p_estop;
		estop_event |=> stat_out.emergency_stop_flag && servo_pwr_q == '0;
	endproperty
	a_estop: assert property (p_estop)
		else $error("emergency stop not flagged");
	property p_slot_start;
		start_rise[0] |=> run_q[0];
	endproperty
	a_slot_start: assert property (p_slot_start)
		else $error("slot did not start on its edge");
	property p_slot_wait;
		run_q[0] && slot_stop[0] |-> slot_waiting[0] && !slot_operating[0];
	endproperty
	a_slot_wait: assert property (p_slot_wait)
		else $error("stopped slot not shown waiting");
	property p_prog_latch;
		rise.program_number_latch |=> prog_q == $past(numeric_value_in);
	endproperty
	a_prog_latch: assert property (p_prog_latch)
		else $error("program number not latched");
	property p_ovrd_latch;
		rise.override_value_latch |=> ovrd_q == $past(numeric_value_in);
	endproperty
	a_ovrd_latch: assert property (p_ovrd_latch)
		else $error("override not latched");
	property p_prog_out;
		rise.program_name_readback |=>
			stat_out.program_name_flag && numeric_value_out == $past(prog_q);
	endproperty
	a_prog_out: assert property (p_prog_out)
		else $error("program readback not presented");
	property p_line_out;
		rise.line_number_readback && !rise.program_name_readback |=>
			stat_out.line_number_flag && numeric_value_out == $past(line_q);
	endproperty
	a_line_out: assert property (p_line_out)
		else $error("line readback not presented");

endmodule : robot_dedicated_io_control
`default_nettype wire

// ### design/robot_io_map.svh
// Register offsets, field positions and reset values of the dedicated I/O block.
//
// Functional notes
// - Level inputs act only while asserted.
// - Servo-off level drops all servos, echoed.
// - Servo-on edge powers every mechanism.
// - In-servo-on shows any mechanism powered.
// - Held rights request reported valid on output.
// - Machine-lock edge toggles lock, shown on output.
// - Evasion edge starts return, busy output held.
// - Output-reset edge clears general-purpose outputs.
// - Emergency stop output flags occurred stop.
// - Per-slot start edge runs own slot only.
// - Per-slot stop level pauses slot, wait shown.
// - Program-select edge latches numeric input bus.
// - Override-select edge latches numeric input bus.
// - Numeric output bus carries readback values.
// - Program request shows program on bus, flagged.
// - Line request shows line number, flagged.
`ifndef ROBOT_IO_MAP_SVH
`define ROBOT_IO_MAP_SVH

`define RIO_CTRL_OFS 12'h000
`define RIO_STATUS_OFS 12'h004
`define RIO_EVENT_OFS 12'h008
`define RIO_SLOT_OFS 12'h00C
`define RIO_GPOUT_OFS 12'h010
`define RIO_LINE_OFS 12'h014
`define RIO_SEL_OFS 12'h018
`define RIO_IRQ_STAT_OFS 12'h01C
`define RIO_IRQ_MASK_OFS 12'h020

`define RIO_CTRL_RIGHTS_BIT 0
`define RIO_CTRL_RST 1'h1

`define RIO_ST_SERVO_ANY_BIT 0
`define RIO_ST_SERVO_OFF_BIT 1
`define RIO_ST_RIGHTS_BIT 2
`define RIO_ST_LOCK_BIT 3
`define RIO_ST_EVASION_BIT 4
`define RIO_ST_ESTOP_BIT 5
`define RIO_ST_MECH_LSB 8

`define RIO_EV_EVASION_DONE_BIT 0
`define RIO_EV_ESTOP_CLR_BIT 1
`define RIO_EV_MECH_DROP_LSB 8

`define RIO_IRQ_W 6
`define RIO_IRQ_ESTOP_BIT 0
`define RIO_IRQ_EVASION_BIT 1
`define RIO_IRQ_SLOT_BIT 2
`define RIO_IRQ_PROG_BIT 3
`define RIO_IRQ_OVRD_BIT 4
`define RIO_IRQ_SERVO_BIT 5
`define RIO_IRQ_MASK_RST 6'h00

`endif

// ### design/robot_io_pkg.sv
// Types shared by the dedicated I/O command interpreter.
package robot_io_pkg;

	typedef struct packed {
		logic servo_off_hold;
		logic servo_power_request;
		logic external_control_rights;
		logic machine_lock_toggle;
		logic evasion_return_request;
		logic general_output_clear;
		logic program_number_latch;
		logic override_value_latch;
		logic program_name_readback;
		logic line_number_readback;
	} cmd_in_t;

	typedef struct packed {
		logic servo_off_echo;
		logic in_servo_on;
		logic rights_valid;
		logic machine_locked;
		logic evasion_busy;
		logic emergency_stop_flag;
		logic program_name_flag;
		logic line_number_flag;
	} stat_out_t;

	typedef enum logic [2:0] {
		RB_IDLE = 3'b001,
		RB_PROG = 3'b010,
		RB_LINE = 3'b100
	} readback_t;

endpackage : robot_io_pkg

// ### dv/plc_model.sv
// Behavioural model of the external controller that drives the dedicated I/O.
`timescale 1ns/100ps
`default_nettype none

module plc_model import robot_io_pkg::*; (
	input wire logic pclk,
	output var cmd_in_t cmd_in,
	output var logic [31:0] slot_start,
	output var logic [31:0] slot_stop,
	output var logic [15:0] numeric_value_in,
	output var logic estop_event
);

	initial begin
		cmd_in = '0;
		slot_start = 32'h0;
		slot_stop = 32'h0;
		numeric_value_in = 16'h0;
		estop_event = 1'b0;
	end

	// Edge commands get one high cycle and are then released low.
	task pulse(input logic [9:0] m);
		@(posedge pclk);
		cmd_in <= cmd_in | m;
		@(posedge pclk);
		cmd_in <= cmd_in & ~m;
	endtask : pulse

	// Level commands stay where they are put, so rights are held asserted.
	task hold(input logic [9:0] m, input logic v);
		@(posedge pclk);
		cmd_in <= v ? (cmd_in | m) : (cmd_in & ~m);
	endtask : hold

	task start_slots(input logic [31:0] m);
		@(posedge pclk);
		slot_start <= m;
		@(posedge pclk);
		slot_start <= 32'h0;
	endtask : start_slots

	task stop_slots(input logic [31:0] m);
		@(posedge pclk);
		slot_stop <= m;
	endtask : stop_slots

	// The numeric bus is presented as a level and kept until replaced.
	task put_value(input logic [15:0] v);
		@(posedge pclk);
		numeric_value_in <= v;
	endtask : put_value

	task estop;
		@(posedge pclk);
		estop_event <= 1'b1;
		@(posedge pclk);
		estop_event <= 1'b0;
	endtask : estop

endmodule : plc_model

`default_nettype wire

// ### dv/robot_dedicated_io_control_tb.sv
// Self-checking testbench of the dedicated I/O command interpreter.
`timescale 1ns/100ps
`default_nettype none

module robot_dedicated_io_control_tb import robot_io_pkg::*;;
	localparam logic [9:0] C_OFF = 10'h200;
	localparam logic [9:0] C_ON = 10'h100;
	localparam logic [9:0] C_RIGHTS = 10'h080;
	localparam logic [9:0] C_LOCK = 10'h040;
	localparam logic [9:0] C_EVA = 10'h020;
	localparam logic [9:0] C_CLR = 10'h010;
	localparam logic [9:0] C_PSEL = 10'h008;
	localparam logic [9:0] C_OSEL = 10'h004;
	localparam logic [9:0] C_PRB = 10'h002;
	localparam logic [9:0] C_LRB = 10'h001;
	logic pclk = 1'b0;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata, rd, slot_start, slot_stop, slot_operating;
	logic [31:0] slot_waiting, general_out;
	logic pready, pslverr, irq, er, estop_event;
	logic [15:0] numeric_value_in, numeric_value_out;
	logic [2:0] servo_power;
	cmd_in_t cmd_in;
	stat_out_t stat_out;
	int failures = 0;
	int n_tests = 0;

	always #12.5 pclk = ~pclk;

	plc_model i_plc (.pclk(pclk), .cmd_in(cmd_in), .slot_start(slot_start),
		.slot_stop(slot_stop), .numeric_value_in(numeric_value_in),
		.estop_event(estop_event));

	robot_dedicated_io_control i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_in(cmd_in),
		.slot_start(slot_start), .slot_stop(slot_stop),
		.numeric_value_in(numeric_value_in), .estop_event(estop_event),
		.stat_out(stat_out), .slot_operating(slot_operating),
		.slot_waiting(slot_waiting), .numeric_value_out(numeric_value_out),
		.servo_power(servo_power), .general_out(general_out), .irq(irq));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task complete_run;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick

	// One APB transfer; the request stands until pready is seen high.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) begin
			failures++;
			$display("Error pready expected 1 seen %b", pready);
		end
	endtask : apb

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_reset;
		chk("stat_out", 32'h0, stat_out);
		chk("servo_power", 32'h0, servo_power);
		chk("irq", 32'h0, irq);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl", 32'h1, rd);
		apb(1'b0, 12'h020, 32'h0);
		chk("irq_mask", 32'h0, rd);
	endtask : t_reset

	task t_servo;
		i_plc.hold(C_ON, 1'b1);
		tick(3);
		chk("servo_power", 32'h7, servo_power);
		apb(1'b1, 12'h008, 32'h100);
		tick(3);
		chk("servo_power", 32'h6, servo_power);
		chk("in_servo_on", 32'h1, stat_out.in_servo_on);
		i_plc.hold(C_ON, 1'b0);
		i_plc.hold(C_OFF, 1'b1);
		tick(3);
		chk("servo_power", 32'h0, servo_power);
		chk("servo_off_echo", 32'h1, stat_out.servo_off_echo);
		chk("in_servo_on", 32'h0, stat_out.in_servo_on);
		i_plc.pulse(C_ON);
		tick(3);
		chk("servo_power", 32'h0, servo_power);
		i_plc.hold(C_OFF, 1'b0);
		tick(3);
		chk("servo_off_echo", 32'h0, stat_out.servo_off_echo);
		i_plc.pulse(C_ON);
		tick(3);
		chk("servo_power", 32'h7, servo_power);
	endtask : t_servo

	task t_rights_lock;
		i_plc.hold(C_RIGHTS, 1'b1);
		tick(3);
		chk("rights_valid", 32'h1, stat_out.rights_valid);
		apb(1'b0, 12'h004, 32'h0);
		chk("status_rights", 32'h1, rd[2]);
		apb(1'b1, 12'h000, 32'h0);
		tick(2);
		chk("rights_valid", 32'h0, stat_out.rights_valid);
		apb(1'b1, 12'h000, 32'h1);
		tick(2);
		chk("rights_valid", 32'h1, stat_out.rights_valid);
		i_plc.hold(C_RIGHTS, 1'b0);
		tick(3);
		chk("rights_valid", 32'h0, stat_out.rights_valid);
		i_plc.pulse(C_LOCK);
		tick(3);
		chk("machine_locked", 32'h1, stat_out.machine_locked);
		i_plc.hold(C_LOCK, 1'b1);
		tick(6);
		chk("machine_locked", 32'h0, stat_out.machine_locked);
		i_plc.hold(C_LOCK, 1'b0);
	endtask : t_rights_lock

	task t_evasion_gpout;
		i_plc.pulse(C_EVA);
		tick(8);
		chk("evasion_busy", 32'h1, stat_out.evasion_busy);
		apb(1'b1, 12'h008, 32'h1);
		tick(2);
		chk("evasion_busy", 32'h0, stat_out.evasion_busy);
		apb(1'b1, 12'h010, 32'hA5A55A5A);
		tick(2);
		chk("general_out", 32'hA5A55A5A, general_out);
		i_plc.pulse(C_CLR);
		tick(3);
		chk("general_out", 32'h0, general_out);
	endtask : t_evasion_gpout

	task t_estop;
		apb(1'b1, 12'h020, 32'h1);
		i_plc.estop;
		tick(3);
		chk("emergency_stop_flag", 32'h1, stat_out.emergency_stop_flag);
		chk("irq", 32'h1, irq);
		apb(1'b0, 12'h01C, 32'h0);
		chk("irq_stat", 32'h1, rd[0]);
		tick(1);
		chk("irq", 32'h0, irq);
		apb(1'b1, 12'h008, 32'h2);
		tick(2);
		chk("emergency_stop_flag", 32'h0, stat_out.emergency_stop_flag);
		apb(1'b1, 12'h020, 32'h0);
		i_plc.estop;
		tick(3);
		chk("irq", 32'h0, irq);
		apb(1'b0, 12'h01C, 32'h0);
		chk("irq_stat", 32'h1, rd[0]);
	endtask : t_estop

	task t_slots;
		i_plc.start_slots(32'h80000001);
		tick(3);
		chk("slot_operating", 32'h80000001, slot_operating);
		i_plc.stop_slots(32'h80000000);
		tick(2);
		chk("slot_waiting", 32'h80000000, slot_waiting);
		chk("slot_operating", 32'h00000001, slot_operating);
		i_plc.stop_slots(32'h0);
		tick(2);
		chk("slot_operating", 32'h80000001, slot_operating);
		apb(1'b1, 12'h00C, 32'h1);
		tick(2);
		chk("slot_operating", 32'h80000000, slot_operating);
		i_plc.estop;
		tick(2);
		chk("slot_operating", 32'h0, slot_operating);
	endtask : t_slots

	task t_numeric;
		i_plc.put_value(16'h1234);
		i_plc.pulse(C_PSEL);
		i_plc.put_value(16'h00C8);
		i_plc.pulse(C_OSEL);
		i_plc.put_value(16'hFFFF);
		tick(3);
		apb(1'b0, 12'h018, 32'h0);
		chk("selection", 32'h00C81234, rd);
		i_plc.pulse(C_PRB);
		tick(3);
		chk("program_name_flag", 32'h1, stat_out.program_name_flag);
		chk("numeric_value_out", 32'h1234, numeric_value_out);
		apb(1'b1, 12'h014, 32'h42);
		i_plc.pulse(C_LRB);
		tick(3);
		chk("line_number_flag", 32'h1, stat_out.line_number_flag);
		chk("program_name_flag", 32'h0, stat_out.program_name_flag);
		chk("numeric_value_out", 32'h42, numeric_value_out);
	endtask : t_numeric

	task t_unmapped;
		apb(1'b0, 12'h024, 32'h0);
		chk("pslverr", 32'h1, er);
		chk("prdata", 32'h0, rd);
	endtask : t_unmapped

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		t_reset;
		t_servo;
		t_rights_lock;
		t_evasion_gpout;
		t_estop;
		t_slots;
		t_numeric;
		t_unmapped;
		complete_run;
	end

	initial begin
		#500000;
		failures++;
		complete_run;
	end

endmodule : robot_dedicated_io_control_tb

`default_nettype wire
